// *** core/fdu_divide.sv ***
// iterative floating divide unit with an AHB-Lite status/control slave
//
// Implementation choices: the address map and the AHB-Lite interface to the registers.
`include "fdu_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module fdu_divide (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // register bus
   input wire fdu_pkg::fdu_ahb_req_s ahb_req,
   output var fdu_pkg::fdu_ahb_rsp_s ahb_rsp,
   // instruction issue
   input wire fdu_pkg::fdu_issue_s issue,
   input wire fdu_pkg::fdu_word_t dividend_operand_reg,
   input wire fdu_pkg::fdu_word_t divisor_operand_reg,
   output logic div_busy,
   // destination register input control
   output var fdu_pkg::fdu_result_s dest_result
);
   import fdu_pkg::*;

   // ==================================================================
   // state
   fdu_state_s st_r;
   fdu_state_s st_nxt;

   logic issue_acc;
   logic [47:0] jc;
   logic [47:0] kc;
   logic [10:0] je;
   logic [10:0] ke;
   logic [50:0] dvs;
   logic [50:0] rem_cur;
   logic [50:0] mult [1:7];
   logic [7:1] fits;
   logic [2:0] pick;
   logic [50:0] diff;
   logic signed [12:0] ej;
   logic signed [12:0] ek;
   logic signed [12:0] cf;
   logic signed [12:0] e_res;
   logic [12:0] e_pack;
   logic jo, ju, ji, ko, ku, ki;
   logic ind_c, ovf_c, unf_c;
   logic special;
   logic ap_take;
   logic [31:0] rd_word;

   function automatic logic signed [12:0] fdu_unbias(input logic [10:0] f);
      logic [12:0] w;
      w = {2'b00, f};
      fdu_unbias = f[10] ? signed'(w - `FDU_BIAS_POS) : signed'(w - `FDU_BIAS_NEG);
   endfunction : fdu_unbias

   // ==================================================================
   // operand conditioning
   assign jc = st_r.j_in[59] ? ~st_r.j_in[47:0] : st_r.j_in[47:0];
   assign kc = st_r.k_in[59] ? ~st_r.k_in[47:0] : st_r.k_in[47:0];
   assign je = st_r.j_in[59] ? ~st_r.j_in[58:48] : st_r.j_in[58:48];
   assign ke = st_r.k_in[59] ? ~st_r.k_in[58:48] : st_r.k_in[58:48];
   assign dvs = {3'b000, kc};

   assign issue_acc = issue.valid && !st_r.busy && st_r.ctrl_en &&
                      (issue.opcode == `FDU_OP_DIV || issue.opcode == `FDU_OP_RDIV);

   // ==================================================================
   // multiple network and trial subtraction
   genvar g;
   generate
      for (g = 1; g <= 7; g++) begin : g_mult
         assign mult[g] = 51'(dvs * 51'(g));
         assign fits[g] = (rem_cur >= mult[g]);
      end
   endgenerate

   // dividend enters with bits 48..50 clear on the first step
   assign rem_cur = (st_r.iter == 5'h01) ? {3'b000, jc} : st_r.rem;

   always_comb begin
      pick = 3'h0;
      for (int i = 1; i <= 7; i++) begin
         if (fits[i]) begin
            pick = 3'(i);
         end
      end
   end

   assign diff = (pick == 3'h0) ? rem_cur : rem_cur - mult[pick];

   // ==================================================================
   // exponent network
   assign ej = fdu_unbias(je);
   assign ek = fdu_unbias(ke);
   assign cf = st_r.fd[0] ? signed'(`FDU_CF_INT) : signed'(`FDU_CF_FRAC);
   assign e_res = ej - ek - cf;
   assign e_pack = (e_res >= 13'sh0000) ? 13'(e_res + `FDU_BIAS_POS) :
                                          13'(e_res + `FDU_BIAS_NEG);

   assign jo = (je == `FDU_EXP_OVF);
   assign ju = (je == `FDU_EXP_UNF);
   assign ji = (je == `FDU_EXP_IND);
   assign ko = (ke == `FDU_EXP_OVF);
   assign ku = (ke == `FDU_EXP_UNF);
   assign ki = (ke == `FDU_EXP_IND);
   assign ind_c = ji || ki || (jo && ko) || (ju && ku) || st_r.ratio2;
   assign ovf_c = !ind_c && (jo || ku ||
                  (!ju && !ko && e_res > signed'(`FDU_EXP_MAX)));
   assign unf_c = !ind_c && !ovf_c && (ju || ko || e_res < signed'(`FDU_EXP_MIN));
   assign special = st_r.indef || st_r.ovf || st_r.unf;

   // ==================================================================
   // bus decode
   assign ap_take = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;

   always_comb begin
      rd_word = 32'h0000_0000;
      case (ahb_req.haddr[7:0])
         `FDU_REG_CTRL: begin
            rd_word = {31'h0000_0000, st_r.ctrl_en};
         end
         `FDU_REG_STATUS: begin
            rd_word = {24'h00_0000, st_r.last_fd, st_r.res.unf, st_r.res.ovf,
                       st_r.res.indef, st_r.res.special, st_r.busy};
         end
         `FDU_REG_COUNT: begin
            rd_word = {16'h0000, st_r.done_cnt};
         end
         default: begin
            rd_word = 32'h0000_0000;
         end
      endcase
   end

   // ==================================================================
   // next state
   always_comb begin
      st_nxt = st_r;
      st_nxt.res.strobe = 1'b0;

      // operating registers flow in while idle
      if (!st_r.busy) begin
         st_nxt.j_in = dividend_operand_reg;
         st_nxt.k_in = divisor_operand_reg;
         st_nxt.rnd = issue.m_desig[0];
      end

      // iterative section
      if (issue_acc) begin
         st_nxt.busy = 1'b1;
         st_nxt.iter = 5'h01;
      end else if (st_r.busy) begin
         if (st_r.iter == `FDU_ITERS) begin
            st_nxt.busy = 1'b0;
            st_nxt.iter = 5'h00;
         end else begin
            st_nxt.iter = st_r.iter + 5'h01;
         end
      end

      if (st_r.busy) begin
         st_nxt.rem = {diff[47:0], 3'h0};
         if (st_r.iter == 5'h01) begin
            if (st_r.rnd) begin
               st_nxt.rem = {diff[47:0], `FDU_RND_FILL};
            end
            st_nxt.ratio2 = (pick >= `FDU_FORCED_DIGIT);
            st_nxt.fd = (pick >= `FDU_FORCED_DIGIT) ? `FDU_FORCED_DIGIT : pick;
         end else begin
            st_nxt.quotient_shift_value = {st_r.quotient_shift_value[44:0], pick};
         end
         if (st_r.iter == `FDU_CF_CLK) begin
            st_nxt.exp = e_pack[10:0];
            st_nxt.indef = ind_c;
            st_nxt.ovf = ovf_c;
            st_nxt.unf = unf_c;
         end
      end

      // output chain, clocks 18 and 19 after issue
      case (st_r.out)
         FDU_OUT_IDLE: begin
            if (st_r.busy && st_r.iter == `FDU_ITERS) begin
               st_nxt.out = FDU_OUT_HOLD;
            end
         end
         FDU_OUT_HOLD: begin
            st_nxt.out = FDU_OUT_ASM;
         end
         FDU_OUT_ASM: begin
            st_nxt.out = FDU_OUT_IDLE;
            st_nxt.res.strobe = 1'b1;
            st_nxt.res.sign = st_r.j_in[59] ^ st_r.k_in[59];
            st_nxt.res.special = special;
            st_nxt.res.indef = st_r.indef;
            st_nxt.res.ovf = st_r.ovf;
            st_nxt.res.unf = st_r.unf;
            st_nxt.last_fd = st_r.fd;
            if (special) begin
               st_nxt.res.coef = 48'hFFFF_FFFF_FFFF;
               st_nxt.res.exp = 11'h7FF;
            end else if (st_r.fd[0]) begin
               st_nxt.res.coef = {1'b1, st_r.quotient_shift_value[47:1]};
               st_nxt.res.exp = st_r.exp;
            end else begin
               st_nxt.res.coef = st_r.quotient_shift_value;
               st_nxt.res.exp = st_r.exp;
            end
         end
         default: begin
            st_nxt.out = FDU_OUT_IDLE;
         end
      endcase

      // bus slave: zero wait states, always OKAY
      st_nxt.rsp.hreadyout = 1'b1;
      st_nxt.rsp.hresp = 1'b0;
      st_nxt.ap_valid = ap_take;
      st_nxt.ap_write = ahb_req.hwrite;
      st_nxt.ap_addr = ahb_req.haddr[7:0];
      if (ap_take && !ahb_req.hwrite) begin
         st_nxt.rsp.hrdata = rd_word;
      end

      // completion count: a write clears, a completion in the same clock still counts
      if (st_r.ap_valid && st_r.ap_write && st_r.ap_addr == `FDU_REG_COUNT) begin
         st_nxt.done_cnt = st_r.out == FDU_OUT_ASM ? 16'h0001 : 16'h0000;
      end else if (st_r.out == FDU_OUT_ASM) begin
         st_nxt.done_cnt = st_r.done_cnt + 16'h0001;
      end
      if (st_r.ap_valid && st_r.ap_write && st_r.ap_addr == `FDU_REG_CTRL) begin
         st_nxt.ctrl_en = ahb_req.hwdata[0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= '0;
         st_r.ctrl_en <= `FDU_CTRL_RST;
         st_r.rsp.hreadyout <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign ahb_rsp = st_r.rsp;
   assign div_busy = st_r.busy;
   assign dest_result = st_r.res;

   // ==================================================================
   // checks
   a_busy_window: assert property (@(posedge hclk) disable iff (!hresetn)
      issue_acc |=> st_r.busy [*8] ##1 st_r.busy [*8] ##1 st_r.busy ##1 !st_r.busy)
      else $error("busy window is not 17 clocks");
   a_done_latency: assert property (@(posedge hclk) disable iff (!hresetn)
      issue_acc |-> ##20 st_r.res.strobe)
      else $error("result not presented 20 clocks after issue");
   a_strobe_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
      st_r.res.strobe |=> !st_r.res.strobe)
      else $error("result strobe longer than one clock");
   a_sign_xor: assert property (@(posedge hclk) disable iff (!hresetn)
      issue_acc ##20 st_r.res.strobe |->
      st_r.res.sign == $past(dividend_operand_reg[59] ^ divisor_operand_reg[59], 20))
      else $error("result sign is not the xor of operand signs");
   a_in_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      st_r.busy |=> $stable(st_r.j_in) && $stable(st_r.k_in))
      else $error("input registers changed while busy");
   a_in_load: assert property (@(posedge hclk) disable iff (!hresetn)
      !st_r.busy |=> st_r.j_in == $past(dividend_operand_reg))
      else $error("input register did not reload while idle");
   a_special_ones: assert property (@(posedge hclk) disable iff (!hresetn)
      st_r.res.strobe && st_r.res.special |->
      st_r.res.coef == 48'hFFFF_FFFF_FFFF && st_r.res.exp == 11'h7FF)
      else $error("special case quotient not all ones");
   a_rem_bound: assert property (@(posedge hclk) disable iff (!hresetn)
      st_r.busy && st_r.iter >= 5'h02 && !st_r.ratio2 |-> st_r.rem < {dvs[47:0], 3'h7})
      else $error("partial remainder out of range");
   a_ratio_indef: assert property (@(posedge hclk) disable iff (!hresetn)
      st_r.res.strobe && st_r.last_fd == `FDU_FORCED_DIGIT |-> st_r.res.indef && st_r.res.special)
      else $error("ratio of two or more not flagged indefinite");
   c_issue: cover property (@(posedge hclk) disable iff (!hresetn) issue_acc);
   c_normal: cover property (@(posedge hclk) disable iff (!hresetn)
      st_r.res.strobe && !st_r.res.special);
   c_special: cover property (@(posedge hclk) disable iff (!hresetn)
      st_r.res.strobe && st_r.res.special);
   c_back_to_back: cover property (@(posedge hclk) disable iff (!hresetn)
      issue_acc ##18 issue_acc);
endmodule : fdu_divide
`default_nettype wire

// *** inc/fdu_defines.svh ***
// register offsets, reset values, encodings and sequence counts of the divide unit
`ifndef FDU_DEFINES_SVH
`define FDU_DEFINES_SVH
// ==================================================================
// register map (byte addresses)
`define FDU_REG_CTRL 8'h00
`define FDU_REG_STATUS 8'h04
`define FDU_REG_COUNT 8'h08
`define FDU_CTRL_RST 1'b1
// ==================================================================
// instruction codes (octal 44 and 45)
`define FDU_OP_DIV 6'h24
`define FDU_OP_RDIV 6'h25
// ==================================================================
// sequence counts in clocks after issue
`define FDU_ITERS 5'h11
`define FDU_CF_CLK 5'h04
// ==================================================================
// exponent constants: correction factors 60 and 57 octal, bias, range
`define FDU_CF_FRAC 13'h0030
`define FDU_CF_INT 13'h002F
`define FDU_BIAS_POS 13'h0400
`define FDU_BIAS_NEG 13'h03FF
`define FDU_EXP_MAX 13'h03FF
`define FDU_EXP_MIN 13'h1C02
`define FDU_EXP_OVF 11'h7FF
`define FDU_EXP_UNF 11'h000
`define FDU_EXP_IND 11'h3FF
// ==================================================================
// digit handling
`define FDU_RND_FILL 3'h5
`define FDU_FORCED_DIGIT 3'h2
`endif

// *** inc/fdu_pkg.sv ***
// types shared by the floating divide unit and its surroundings
package fdu_pkg;
   typedef logic [59:0] fdu_word_t;
   typedef enum logic [1:0] {
      FDU_OUT_IDLE = 2'b00,
      FDU_OUT_HOLD = 2'b01,
      FDU_OUT_ASM = 2'b10
   } fdu_out_e;
   typedef struct packed {
      logic valid;
      logic [5:0] opcode;
      logic [2:0] m_desig;
   } fdu_issue_s;
   typedef struct packed {
      logic strobe;
      logic sign;
      logic [10:0] exp;
      logic [47:0] coef;
      logic special;
      logic indef;
      logic ovf;
      logic unf;
   } fdu_result_s;
   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } fdu_ahb_req_s;
   typedef struct packed {
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
   } fdu_ahb_rsp_s;
   typedef struct packed {
      fdu_word_t j_in;
      fdu_word_t k_in;
      logic rnd;
      logic busy;
      logic [4:0] iter;
      fdu_out_e out;
      logic [50:0] rem;
      logic [47:0] quotient_shift_value;
      logic [2:0] fd;
      logic ratio2;
      logic [10:0] exp;
      logic indef;
      logic ovf;
      logic unf;
      fdu_result_s res;
      logic [2:0] last_fd;
      logic ctrl_en;
      logic [15:0] done_cnt;
      logic ap_valid;
      logic ap_write;
      logic [7:0] ap_addr;
      fdu_ahb_rsp_s rsp;
   } fdu_state_s;
endpackage : fdu_pkg

// *** dv/fdu_issue_model.sv ***
// partner model: instruction issue logic and destination register input control
`timescale 1ns/100ps
`default_nettype none
module fdu_issue_model (
   // clock
   input wire logic hclk,
   // issue side
   output var fdu_pkg::fdu_issue_s issue,
   output var fdu_pkg::fdu_word_t j_op,
   output var fdu_pkg::fdu_word_t k_op,
   // result side
   input wire fdu_pkg::fdu_result_s dest_result,
   output var fdu_pkg::fdu_result_s got,
   output var int lat,
   output var int n_res
);
   import fdu_pkg::*;
   int since = 99;
   initial begin
      issue = '0;
      j_op = '0;
      k_op = '0;
      got = '0;
      lat = 0;
      n_res = 0;
   end
   // ==================================================================
   // clocks since the last issue pulse; result latched on its strobe
   always @(posedge hclk) begin
      since <= issue.valid ? 1 : since + 1;
      if (dest_result.strobe === 1'b1) begin
         got <= dest_result;
         lat <= since;
         n_res <= n_res + 1;
      end
   end
   // ==================================================================
   // one issue pulse; early skips the wait for the busy window
   task automatic send(input logic [5:0] op, input logic rnd, input fdu_word_t j,
         input fdu_word_t k, input bit early);
      @(posedge hclk);
      while (!early && since < 17) begin
         @(posedge hclk);
      end
      issue <= '{1'b1, op, {2'b00, rnd}};
      j_op <= j;
      k_op <= k;
      @(posedge hclk);
      issue.valid <= 1'b0;
      j_op <= ~j;
      k_op <= ~k;
   endtask : send
endmodule : fdu_issue_model
`default_nettype wire

// *** dv/floating_point_divide_unit_tb.sv ***
// self-checking testbench of the floating divide unit
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
   $display("mismatch at %0t got %h expected %h", $time, a, b); end end
module floating_point_divide_unit_tb;
   import fdu_pkg::*;
   typedef struct packed {
      logic [5:0] op;
      logic rnd;
      fdu_word_t j;
      fdu_word_t k;
      logic sign;
      logic [10:0] exp;
      logic [47:0] coef;
      logic [3:0] flags;
   } fdu_row_s;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   fdu_ahb_req_s m = '0;
   fdu_ahb_rsp_s rsp;
   fdu_issue_s issue;
   fdu_word_t j_op;
   fdu_word_t k_op;
   fdu_result_s res;
   fdu_result_s got;
   logic busy;
   logic [31:0] rd;
   int lat;
   int n_res;
   int n0;
   int mismatches = 0;
   int check_count = 0;
   fdu_row_s rows [12];
   wire fdu_ahb_req_s bus_req = {m[71:1], rsp.hreadyout};
   fdu_divide dut (.hclk(hclk), .hresetn(hresetn), .ahb_req(bus_req), .ahb_rsp(rsp),
      .issue(issue), .dividend_operand_reg(j_op), .divisor_operand_reg(k_op),
      .div_busy(busy), .dest_result(res));
   fdu_issue_model u_src (.hclk(hclk), .issue(issue), .j_op(j_op), .k_op(k_op),
      .dest_result(res), .got(got), .lat(lat), .n_res(n_res));
   initial begin
      forever #5 hclk = ~hclk;
   end
   // ==================================================================
   // tasks
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      m.hsel <= 1'b1;
      m.htrans <= 2'h2;
      m.haddr <= {24'h000000, a};
      m.hwrite <= wr;
      m.hsize <= 3'h2;
      do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
      m.htrans <= 2'h0;
      m.hwdata <= wd;
      do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
      rd = rsp.hrdata;
   endtask : ahb
   task automatic run(input fdu_row_s r);
      n0 = n_res;
      u_src.send(r.op, r.rnd, r.j, r.k, 1'b0);
      repeat (17) @(negedge hclk);
      `CHK(busy, 1'b1)
      @(negedge hclk);
      `CHK(busy, 1'b0)
      for (int i = 0; i < 40 && n_res == n0; i++) @(posedge hclk);
      #1;
      `CHK(lat, 20)
      `CHK({got.sign, got.exp, got.coef}, {r.sign, r.exp, r.coef})
      `CHK({got.special, got.indef, got.ovf, got.unf}, r.flags)
   endtask : run
   task automatic refused(input logic [5:0] op);
      n0 = n_res;
      u_src.send(op, 1'b0, rows[0].j, rows[0].k, 1'b0);
      repeat (30) @(negedge hclk);
      `CHK(busy, 1'b0)
      `CHK(n_res - n0, 0)
   endtask : refused
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : report_and_stop
   // ==================================================================
   // main sequence
   initial begin
      rows = '{
         '{6'h24, 1'b0, 60'h42F90000000000D, 60'h41AC00000000000, 1'b0, 11'h3E4,
           48'hC00000000011, 4'h0},
         '{6'h24, 1'b0, 60'h40EE00000000000, 60'h415800000000000, 1'b0, 11'h3C9,
           48'hE00000000000, 4'h0},
         '{6'h24, 1'b0, 60'hBD06FFFFFFFFFF2, 60'h41AC00000000000, 1'b1, 11'h3E4,
           48'hC00000000011, 4'h0},
         '{6'h24, 1'b0, 60'hBD06FFFFFFFFFF2, 60'hBE53FFFFFFFFFFF, 1'b0, 11'h3E4,
           48'hC00000000011, 4'h0},
         '{6'h24, 1'b0, 60'h400400000000001, 60'h400800000000000, 1'b0, 11'h3CF,
           48'h800000000002, 4'h0},
         '{6'h25, 1'b1, 60'h400400000000001, 60'h400800000000000, 1'b0, 11'h3CF,
           48'h800000000003, 4'h0},
         '{6'h24, 1'b0, 60'h3FF800000000000, 60'h400800000000000, 1'b0, 11'h7FF,
           48'hFFFFFFFFFFFF, 4'hC},
         '{6'h24, 1'b0, 60'h7FF800000000000, 60'h400800000000000, 1'b0, 11'h7FF,
           48'hFFFFFFFFFFFF, 4'hA},
         '{6'h24, 1'b0, 60'h000800000000000, 60'h400800000000000, 1'b0, 11'h7FF,
           48'hFFFFFFFFFFFF, 4'h9},
         '{6'h24, 1'b0, 60'h7FE400000000000, 60'h001800000000000, 1'b0, 11'h7FF,
           48'hFFFFFFFFFFFF, 4'hA},
         '{6'h24, 1'b0, 60'h001400000000000, 60'h7FE800000000000, 1'b0, 11'h7FF,
           48'hFFFFFFFFFFFF, 4'h9},
         '{6'h24, 1'b0, 60'h400800000000000, 60'h400400000000000, 1'b0, 11'h7FF,
           48'hFFFFFFFFFFFF, 4'hC}};
      repeat (16) @(negedge hclk);
      `CHK({busy, rsp, res}, {1'b0, 32'h00000000, 2'b10, 65'h0})
      @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < 4; i++) begin
         ahb(1'b0, 8'(4 * i), 32'h00000000);
         `CHK(rd, (i == 0) ? 32'h00000001 : 32'h00000000)
      end
      $display("test reset done");
      foreach (rows[i]) begin
         run(rows[i]);
      end
      $display("test rows done");
      @(posedge hclk);
      ahb(1'b0, 8'h04, 32'h00000000);
      `CHK(rd, 32'h00000046)
      ahb(1'b0, 8'h08, 32'h00000000);
      `CHK(rd, 32'h0000000C)
      ahb(1'b1, 8'h08, 32'h00000000);
      ahb(1'b0, 8'h08, 32'h00000000);
      `CHK(rd, 32'h00000000)
      $display("test registers done");
      n0 = n_res;
      u_src.send(rows[0].op, 1'b0, rows[0].j, rows[0].k, 1'b0);
      u_src.send(rows[1].op, 1'b0, rows[1].j, rows[1].k, 1'b0);
      repeat (30) @(posedge hclk);
      #1;
      `CHK(n_res - n0, 2)
      `CHK({got.exp, got.coef}, {rows[1].exp, rows[1].coef})
      `CHK(lat, 20)
      n0 = n_res;
      u_src.send(rows[1].op, 1'b0, rows[1].j, rows[1].k, 1'b0);
      repeat (4) @(posedge hclk);
      u_src.send(rows[0].op, 1'b0, rows[0].j, rows[0].k, 1'b1);
      repeat (40) @(posedge hclk);
      #1;
      `CHK(n_res - n0, 1)
      `CHK(got.coef, rows[1].coef)
      $display("test spacing done");
      refused(6'h26);
      @(posedge hclk);
      ahb(1'b1, 8'h00, 32'h00000000);
      refused(6'h24);
      @(posedge hclk);
      ahb(1'b1, 8'h00, 32'h00000001);
      $display("test refusal done");
      n0 = n_res;
      u_src.send(rows[0].op, 1'b0, rows[0].j, rows[0].k, 1'b0);
      repeat (4) @(posedge hclk);
      hresetn <= 1'b0;
      @(negedge hclk);
      `CHK({busy, rsp}, {1'b0, 32'h00000000, 2'b10})
      @(posedge hclk);
      hresetn <= 1'b1;
      repeat (30) @(posedge hclk);
      `CHK(n_res - n0, 0)
      $display("test mid reset done");
      report_and_stop();
   end
   initial begin
      repeat (4000) @(posedge hclk);
      mismatches++;
      report_and_stop();
   end
endmodule : floating_point_divide_unit_tb
`default_nettype wire
